// ### rtl/psf_mdio_engine.sv
`timescale 1ns/1ps
`include "psf_defines.svh"

module psf_mdio_engine
  import psf_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PSF_PHY_ADDR_DEF
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_mdc,
  input wire logic i_mdio_in,
  input wire logic [15:0] i_rd_data,
  output psf_req_s o_req,
  output logic o_mdio_out,
  output logic o_mdio_oe
);

  psf_mdio_st_e st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic mdc_q;
  logic armed_q;
  logic out_q, out_d;
  logic oe_q, oe_d;
  psf_req_s req_q, req_d;
  logic mdc_rise;
  logic [11:0] hdr;

  // The first sample after reset only arms the detector, so a clock left high is no edge.
  assign mdc_rise = i_mdc & ~mdc_q & armed_q;
  assign hdr = {sh_q[10:0], i_mdio_in};

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoding on each rising edge of the management clock.

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = out_q;
    oe_d = oe_q;
    req_d = req_q;
    req_d.wr = 1'b0;
    if (mdc_rise)
    begin
      unique case (st_q)
        PSF_ST_PRE:
        begin
          if (i_mdio_in)
            cnt_d = (cnt_q == `PSF_PRE_LEN) ? cnt_q : cnt_q + 6'h01;
          else if (cnt_q == `PSF_PRE_LEN)
            st_d = PSF_ST_START;
          else
            cnt_d = 6'h00;
        end
        PSF_ST_START:
        begin
          cnt_d = 6'h00;
          st_d = i_mdio_in ? PSF_ST_HDR : PSF_ST_PRE;
        end
        PSF_ST_HDR:
        begin
          sh_d = {sh_q[14:0], i_mdio_in};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h0b)
          begin
            cnt_d = 6'h00;
            req_d.addr = hdr[4:0];
            if (hdr[9:5] != PHY_ADDR)
              st_d = PSF_ST_PRE;
            else if (hdr[11:10] == `PSF_OP_RD)
              st_d = PSF_ST_RTA;
            else if (hdr[11:10] == `PSF_OP_WR)
              st_d = PSF_ST_WTA;
            else
              st_d = PSF_ST_PRE;
          end
        end
        PSF_ST_RTA:
        begin
          oe_d = 1'b1;
          out_d = 1'b0;
          sh_d = i_rd_data;
          st_d = PSF_ST_RDATA;
        end
        PSF_ST_RDATA:
        begin
          if (cnt_q == 6'h10)
          begin
            oe_d = 1'b0;
            out_d = 1'b0;
            cnt_d = 6'h00;
            st_d = PSF_ST_PRE;
          end
          else
          begin
            out_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
            cnt_d = cnt_q + 6'h01;
          end
        end
        PSF_ST_WTA:
        begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h01)
          begin
            cnt_d = 6'h00;
            st_d = PSF_ST_WDATA;
          end
        end
        PSF_ST_WDATA:
        begin
          sh_d = {sh_q[14:0], i_mdio_in};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h0f)
          begin
            req_d.wr = 1'b1;
            req_d.data = {sh_q[14:0], i_mdio_in};
            cnt_d = 6'h00;
            st_d = PSF_ST_PRE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_q <= PSF_ST_PRE;
      cnt_q <= 6'h00;
      sh_q <= 16'h0000;
      mdc_q <= 1'b0;
      armed_q <= 1'b0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      mdc_q <= i_mdc;
      armed_q <= 1'b1;
      out_q <= out_d;
      oe_q <= oe_d;
      req_q <= req_d;
    end
  end

  assign o_req = req_q;
  assign o_mdio_out = out_q;
  assign o_mdio_oe = oe_q;

endmodule

// ### rtl/psf_defines.svh
`ifndef PSF_DEFINES_SVH
`define PSF_DEFINES_SVH

// Management frame layout.
`define PSF_PRE_LEN 6'h20
`define PSF_OP_RD 2'h2
`define PSF_OP_WR 2'h1
`define PSF_PHY_ADDR_DEF 5'h01

// Register offset.
`define PSF_REG_SPECIAL 5'h1b

// Field positions.
`define PSF_LEN_HI 15
`define PSF_LEN_LO 13
`define PSF_RISE_HI 11
`define PSF_RISE_LO 10
`define PSF_AMDIX_BIT 9
`define PSF_MDIX_BIT 8
`define PSF_ALB_BIT 7
`define PSF_LDE_BIT 6
`define PSF_LSE_BIT 5
`define PSF_LDET_BIT 4

// Reset values.
`define PSF_LEN_RST 3'h0
`define PSF_RISE_RST 2'h0
`define PSF_AMDIX_RST 1'h1
`define PSF_MDIX_RST 1'h1
`define PSF_ALB_RST 1'h0
`define PSF_LDE_RST 1'h0
`define PSF_LSE_RST 1'h0
`define PSF_LDET_RST 1'h0

// Rise-time codes.
`define PSF_RISE_3P3NS 2'h0
`define PSF_RISE_3P6NS 2'h1
`define PSF_RISE_3P9NS 2'h2
`define PSF_RISE_4P2NS 2'h3

// Loopback qualification times and derived cycle counts.
`define PSF_CLK_PERIOD_NS 10
`define PSF_LPBK_QUAL_NS 2000
`define PSF_LPBK_FAST_NS 500
`define PSF_LPBK_QUAL_CYC ((`PSF_LPBK_QUAL_NS + `PSF_CLK_PERIOD_NS - 1) / `PSF_CLK_PERIOD_NS)
`define PSF_LPBK_FAST_CYC ((`PSF_LPBK_FAST_NS + `PSF_CLK_PERIOD_NS - 1) / `PSF_CLK_PERIOD_NS)

`endif

// ### rtl/psf_pkg.sv
package psf_pkg;

  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic [15:0] data;
  } psf_req_s;

  typedef struct packed {
    logic [1:0] rise_sel;
    logic auto_mdix_en;
    logic mdix_sel;
    logic analog_lpbk;
    logic lpbk_det_en;
    logic lpbk_speedup;
  } psf_ctrl_s;

  typedef enum logic [2:0] {
    PSF_ST_PRE,
    PSF_ST_START,
    PSF_ST_HDR,
    PSF_ST_RTA,
    PSF_ST_RDATA,
    PSF_ST_WTA,
    PSF_ST_WDATA
  } psf_mdio_st_e;

endpackage

// ### rtl/psf_special_function.sv
// Functional notes
// - Two-bit rise-time code picks edge rate 3.3, 3.6, 3.9 or 4.2 ns.
// - Rise-time code is loaded from strap pins at hardware reset.
// - Read-write auto crossover enable bit switches automatic MDI/MDIX; resets to one.
// - Read-write pair select: zero is MDI, one is MDIX; resets to one.
// - Analog loopback bit enables loopback while still transmitting; resets to zero.
// - Read-only loopback detected bit shows a detected loopback; resets to zero.
// - Reserved positions are written as zero by software and kept zero.
`timescale 1ns/1ps
`include "psf_defines.svh"

module psf_special_function
  import psf_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PSF_PHY_ADDR_DEF,
  parameter int QUAL_CYC = `PSF_LPBK_QUAL_CYC,
  parameter int FAST_CYC = `PSF_LPBK_FAST_CYC
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_mdc,
  input wire logic i_mdio_in,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  input wire logic [1:0] i_rise_strap,
  input wire logic [2:0] i_line_len,
  input wire logic i_lpbk_seen,
  output psf_ctrl_s o_ctrl,
  output logic o_lpbk_detected
);

  localparam logic [11:0] QUAL_LIM = 12'(QUAL_CYC);
  localparam logic [11:0] FAST_LIM = 12'(FAST_CYC);

  psf_req_s req;
  psf_ctrl_s ctrl_q, ctrl_d;
  logic strap_done_q, strap_done_d;
  logic [2:0] len_q, len_d;
  logic det_q, det_d;
  logic [11:0] qcnt_q, qcnt_d;
  logic [11:0] qlim;
  logic [15:0] rd_data;

  // Assembles the register image; reserved positions always read zero.
  function automatic logic [15:0] sf_image(input psf_ctrl_s c, input logic [2:0] len,
                                           input logic det);
    logic [15:0] v;
    v = 16'h0000;
    v[`PSF_LEN_HI:`PSF_LEN_LO] = len;
    v[`PSF_RISE_HI:`PSF_RISE_LO] = c.rise_sel;
    v[`PSF_AMDIX_BIT] = c.auto_mdix_en;
    v[`PSF_MDIX_BIT] = c.mdix_sel;
    v[`PSF_ALB_BIT] = c.analog_lpbk;
    v[`PSF_LDE_BIT] = c.lpbk_det_en;
    v[`PSF_LSE_BIT] = c.lpbk_speedup;
    v[`PSF_LDET_BIT] = det;
    return v;
  endfunction

  psf_mdio_engine #(
    .PHY_ADDR(PHY_ADDR)
  ) u_mdio (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_mdc(i_mdc),
    .i_mdio_in(i_mdio_in),
    .i_rd_data(rd_data),
    .o_req(req),
    .o_mdio_out(o_mdio_out),
    .o_mdio_oe(o_mdio_oe)
  );

  assign rd_data = (req.addr == `PSF_REG_SPECIAL) ? sf_image(ctrl_q, len_q, det_q) : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields: strap capture after reset, then software writes.

  always_comb
  begin
    ctrl_d = ctrl_q;
    strap_done_d = 1'b1;
    if (!strap_done_q)
      ctrl_d.rise_sel = i_rise_strap;
    if (req.wr && req.addr == `PSF_REG_SPECIAL)
    begin
      ctrl_d.rise_sel = req.data[`PSF_RISE_HI:`PSF_RISE_LO];
      ctrl_d.auto_mdix_en = req.data[`PSF_AMDIX_BIT];
      ctrl_d.mdix_sel = req.data[`PSF_MDIX_BIT];
      ctrl_d.analog_lpbk = req.data[`PSF_ALB_BIT];
      ctrl_d.lpbk_det_en = req.data[`PSF_LDE_BIT];
      ctrl_d.lpbk_speedup = req.data[`PSF_LSE_BIT];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctrl_q.rise_sel <= `PSF_RISE_RST;
      ctrl_q.auto_mdix_en <= `PSF_AMDIX_RST;
      ctrl_q.mdix_sel <= `PSF_MDIX_RST;
      ctrl_q.analog_lpbk <= `PSF_ALB_RST;
      ctrl_q.lpbk_det_en <= `PSF_LDE_RST;
      ctrl_q.lpbk_speedup <= `PSF_LSE_RST;
      strap_done_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      strap_done_q <= strap_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status: line length sample and qualified loopback detection.

  assign qlim = ctrl_q.lpbk_speedup ? FAST_LIM : QUAL_LIM;

  always_comb
  begin
    len_d = i_line_len;
    qcnt_d = 12'h000;
    det_d = 1'b0;
    if (ctrl_q.lpbk_det_en && i_lpbk_seen)
    begin
      if (qcnt_q >= qlim)
      begin
        qcnt_d = qcnt_q;
        det_d = 1'b1;
      end
      else
      begin
        qcnt_d = qcnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      len_q <= `PSF_LEN_RST;
      det_q <= `PSF_LDET_RST;
      qcnt_q <= 12'h000;
    end
    else
    begin
      len_q <= len_d;
      det_q <= det_d;
      qcnt_q <= qcnt_d;
    end
  end

  assign o_ctrl = ctrl_q;
  assign o_lpbk_detected = det_q;

endmodule

// ### sim/psf_sva.sv
`timescale 1ns/1ps
module psf_sva
  import psf_pkg::*;
#(
  parameter int QUAL_CYC = 200,
  parameter int FAST_CYC = 50
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_mdc,
  input wire logic o_mdio_out,
  input wire logic o_mdio_oe,
  input wire logic [1:0] i_rise_strap,
  input wire logic i_lpbk_seen,
  input wire psf_ctrl_s o_ctrl,
  input wire logic o_lpbk_detected
);
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic [15:0] lim;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  // Counts back-to-back cycles of an enabled loopback indication.
  always_comb run_d = (i_lpbk_seen && o_ctrl.lpbk_det_en) ? run_q + 16'h1 : 16'h0;
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
    if (i_sys_rst) run_q <= 16'h0;
    else run_q <= run_d;
  assign lim = o_ctrl.lpbk_speedup ? 16'(FAST_CYC) : 16'(QUAL_CYC);
  ////////////////////////////////////////
  strap_load_a: assert property (
    $fell(i_sys_rst) |=> o_ctrl.rise_sel == $past(i_rise_strap)
  ) else $error("rise code not taken from straps");
  ctrl_rst_a: assert property (
    $fell(i_sys_rst) |-> {o_ctrl[4:0], o_lpbk_detected} == 6'h30
  ) else $error("control reset values wrong");
  det_off_a: assert property (
    !o_ctrl.lpbk_det_en |=> !o_lpbk_detected
  ) else $error("detect flag while detection off");
  det_drop_a: assert property (
    !i_lpbk_seen |=> !o_lpbk_detected
  ) else $error("detect flag without loopback");
  det_qual_a: assert property (
    $rose(o_lpbk_detected) |-> run_q >= lim
  ) else $error("detect flag too early");
  det_late_a: assert property (
    run_q >= lim + 16'h4 |-> o_lpbk_detected
  ) else $error("detect flag too late");
  ta_zero_a: assert property (
    $rose(o_mdio_oe) |-> !o_mdio_out ##0 o_mdio_oe [*8]
  ) else $error("read turnaround wrong");
  ctrl_when_a: assert property (
    $changed(o_ctrl) |-> $past(i_mdc, 2) || $past(i_mdc, 3) || $past(i_sys_rst, 2)
  ) else $error("control changed without a write");
endmodule
bind psf_special_function psf_sva #(.QUAL_CYC(QUAL_CYC), .FAST_CYC(FAST_CYC)) psf_sva_inst (
  .i_core_clk, .i_sys_rst, .i_mdc, .o_mdio_out, .o_mdio_oe,
  .i_rise_strap, .i_lpbk_seen, .o_ctrl, .o_lpbk_detected);

// ### sim/test_phy_special_function.sv
`timescale 1ns/1ps
`include "psf_defines.svh"
module test_phy_special_function
  import psf_pkg::*;
();
  logic i_core_clk, i_sys_rst, i_mdc, host_q, i_mdio_in, i_lpbk_seen;
  logic o_mdio_out, o_mdio_oe, o_lpbk_detected;
  logic [1:0] i_rise_strap;
  logic [2:0] i_line_len;
  logic [15:0] model, rd, wd;
  psf_ctrl_s o_ctrl;
  integer seed = 32'hb95c;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  // The line follows host_q whenever the engine does not drive it; the host sends ones while it lets go.
  assign i_mdio_in = o_mdio_oe ? o_mdio_out : host_q;
  psf_special_function #(.QUAL_CYC(8), .FAST_CYC(3)) psf_special_function_inst (
    .i_core_clk, .i_sys_rst, .i_mdc, .i_mdio_in, .o_mdio_out, .o_mdio_oe,
    .i_rise_strap, .i_line_len, .i_lpbk_seen, .o_ctrl, .o_lpbk_detected);
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] exp_reg(input logic det);
    return {i_line_len, 1'b0, model[11:5], det, 4'h0};
  endfunction
  task automatic mbit(input logic b, output logic r);
    @(posedge i_core_clk);
    i_mdc <= 1'b0;
    host_q <= b;
    repeat (2) @(posedge i_core_clk);
    i_mdc <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1 r = o_mdio_out;
  endtask
  task automatic frame(input logic wr, input logic [4:0] pa, input logic [15:0] d);
    logic r;
    logic [31:0] bits;
    bits = {2'b01, wr ? 2'b01 : 2'b10, pa, `PSF_REG_SPECIAL, 2'b10, d};
    repeat (32) mbit(1'b1, r);
    for (int i = 31; i >= 0; i--)
      if (wr || i > 17) mbit(bits[i], r);
      else
      begin
        mbit(1'b1, r);
        if (i > 0) rd = {rd[14:0], r};
      end
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask
  task automatic rd_check(input logic det);
    frame(1'b0, `PSF_PHY_ADDR_DEF, 16'h0);
    check(rd, exp_reg(det));
    check({15'h0, o_mdio_oe}, 16'h0);
  endtask
  task automatic wr_ctrl(input logic [15:0] d);
    frame(1'b1, `PSF_PHY_ADDR_DEF, d);
    model = d & 16'h0fe0;
    check({9'h0, o_ctrl}, {9'h0, model[11:5]});
  endtask
  task automatic do_reset;
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    i_rise_strap <= 2'($random(seed));
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1 model = {4'h0, i_rise_strap, 2'b11, 8'h0};
    check({9'h0, o_ctrl}, {9'h0, model[11:5]});
    rd_check(1'b0);
  endtask
  task automatic lpbk(input logic sp);
    wr_ctrl(16'h0340 | {10'h0, sp, 5'h0});
    @(posedge i_core_clk);
    i_lpbk_seen <= 1'b1;
    repeat (sp ? 2 : 6) @(posedge i_core_clk);
    #1 check({15'h0, o_lpbk_detected}, 16'h0);
    repeat (sp ? 3 : 4) @(posedge i_core_clk);
    #1 check({15'h0, o_lpbk_detected}, 16'h1);
    rd_check(1'b1);
    @(posedge i_core_clk);
    i_lpbk_seen <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1 check({15'h0, o_lpbk_detected}, 16'h0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    i_sys_rst = 1'b1;
    i_mdc = 1'b0;
    host_q = 1'b1;
    i_lpbk_seen = 1'b0;
    i_rise_strap = 2'h0;
    i_line_len = 3'h0;
    do_reset;
    frame(1'b1, 5'h02, 16'h0000);
    check({9'h0, o_ctrl}, {9'h0, model[11:5]});
    for (int i = 0; i < 6; i++)
    begin
      @(posedge i_core_clk);
      i_line_len <= 3'($random(seed));
      wd = 16'($random(seed));
      wd[11:10] = 2'(i);
      if (i > 3) wd = (i == 4) ? 16'hffff : 16'h0;
      wr_ctrl(wd);
      rd_check(1'b0);
    end
    lpbk(1'b0);
    lpbk(1'b1);
    wr_ctrl(16'h0320);
    @(posedge i_core_clk);
    i_lpbk_seen <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    #1 check({15'h0, o_lpbk_detected}, 16'h0);
    @(posedge i_core_clk);
    i_lpbk_seen <= 1'b0;
    do_reset;
    complete_run;
  end
  initial
  begin
    #500000;
    n_mismatch++;
    complete_run;
  end
endmodule
